// File: rtl/lsdc_pkg.sv
// constants and types shared by the soft-start and dimming slice
package lsdc_pkg;
   // -------------------------------------------------------------
   // channel and step geometry
   // -------------------------------------------------------------
   localparam int         NUM_CH       = 8;
   localparam int         NUM_STEPS    = 8;
   localparam int         STEP_W       = 4;
   // step value 1 means one ninth of full scale, 9 means full scale
   localparam logic [3:0] STEP_INIT    = 4'h1;
   localparam logic [3:0] STEP_FULL    = 4'h9;
   localparam logic [3:0] STEP_INC     = 4'h1;
   localparam logic [3:0] STEP_OFF     = 4'h0;
   localparam logic [7:0] CH_ALL_ON    = 8'hff;
   localparam logic [7:0] CH_ALL_OFF   = 8'h00;
   // -------------------------------------------------------------
   // timing
   // -------------------------------------------------------------
   localparam int         CLK_PERIOD_NS = 10;
   localparam int         STEP_TIME_MS  = 2;
   localparam int         STEP_CYCLES   = (STEP_TIME_MS * 1000000) / CLK_PERIOD_NS;
   localparam int         TMR_W         = 18;
   typedef enum logic [1:0] {LSDC_IDLE, LSDC_RAMP, LSDC_DONE} lsdc_state_e;
endpackage : lsdc_pkg

// File: rtl/lsdc_ss_if.sv
// interface between the top and the soft-start stepper
`timescale 1ns/10ps
interface lsdc_ss_if;
   logic                 run;
   logic                 conduct;
   logic [3:0]           step;
   logic                 done;
   modport top (output run, output conduct, input step, input done);
   modport ss  (input run, input conduct, output step, output done);
endinterface : lsdc_ss_if

// File: rtl/lsdc_softstart.sv
// soft-start current-limit stepper
`timescale 1ns/10ps
module lsdc_softstart #(
   parameter int STEP_CYCLES = lsdc_pkg::STEP_CYCLES
) (
   input  wire logic sys_clk,
   input  wire logic arst_n,
   lsdc_ss_if.ss     ssi
);
   lsdc_pkg::lsdc_state_e state;
   logic [lsdc_pkg::TMR_W-1:0] tmr;
   logic                       seen;
   logic                       interval_up;

   localparam logic [lsdc_pkg::TMR_W-1:0] TMR_LAST = lsdc_pkg::TMR_W'(STEP_CYCLES - 1);
   assign interval_up = (tmr == TMR_LAST);

   // -------------------------------------------------------------
   // interval timer, runs only while ramping
   // -------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         tmr <= '0;
      end else if (!ssi.run || state != lsdc_pkg::LSDC_RAMP) begin
         tmr <= '0;
      end else if (!interval_up) begin
         tmr <= tmr + 1'b1;
      end else if (seen || ssi.conduct) begin
         tmr <= '0;
      end
   end

   // conduction seen since last step; set wins over the step clear
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         seen <= 1'b0;
      end else if (!ssi.run) begin
         seen <= 1'b0;
      end else if (ssi.conduct) begin
         seen <= 1'b1;
      end else if (interval_up) begin
         seen <= 1'b0;
      end
   end

   // -------------------------------------------------------------
   // step sequencer
   // -------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         state    <= lsdc_pkg::LSDC_IDLE;
         ssi.step <= lsdc_pkg::STEP_OFF;
      end else if (!ssi.run) begin
         state    <= lsdc_pkg::LSDC_IDLE;
         ssi.step <= lsdc_pkg::STEP_OFF;
      end else begin
         unique case (state)
            lsdc_pkg::LSDC_IDLE: begin
               state    <= lsdc_pkg::LSDC_RAMP;
               ssi.step <= lsdc_pkg::STEP_INIT;
            end
            lsdc_pkg::LSDC_RAMP: begin
               // hold here while no string conducted in the interval
               if (interval_up && (seen || ssi.conduct)) begin
                  ssi.step <= ssi.step + lsdc_pkg::STEP_INC;
                  if (ssi.step == lsdc_pkg::STEP_FULL - lsdc_pkg::STEP_INC) begin
                     state <= lsdc_pkg::LSDC_DONE;
                  end
               end
            end
            lsdc_pkg::LSDC_DONE: begin
               ssi.step <= lsdc_pkg::STEP_FULL;
            end
         endcase
      end
   end

   assign ssi.done = (state == lsdc_pkg::LSDC_DONE);

   // -------------------------------------------------------------
   // checks
   // -------------------------------------------------------------
   property p_step_bounds;
      @(posedge sys_clk) disable iff (!arst_n)
         ssi.step <= lsdc_pkg::STEP_FULL;
   endproperty
   a_step_bounds: assert property (p_step_bounds) else $error("step above full scale");

   property p_first_step;
      @(posedge sys_clk) disable iff (!arst_n)
         $rose(ssi.run) |=> ssi.step == lsdc_pkg::STEP_INIT;
   endproperty
   a_first_step: assert property (p_first_step) else $error("ramp did not start at one ninth");

   property p_step_by_one;
      @(posedge sys_clk) disable iff (!arst_n)
         ssi.run && $past(ssi.run) && ssi.step != $past(ssi.step)
            |-> ssi.step == $past(ssi.step) + lsdc_pkg::STEP_INC;
   endproperty
   a_step_by_one: assert property (p_step_by_one) else $error("step changed by more than one");

   property p_hold_no_conduct;
      @(posedge sys_clk) disable iff (!arst_n)
         ssi.run && interval_up && !seen && !ssi.conduct && state == lsdc_pkg::LSDC_RAMP
            |=> $stable(ssi.step);
   endproperty
   a_hold_no_conduct: assert property (p_hold_no_conduct) else $error("stepped without conduction");

   property p_restart;
      @(posedge sys_clk) disable iff (!arst_n)
         !ssi.run |=> ssi.step == lsdc_pkg::STEP_OFF;
   endproperty
   a_restart: assert property (p_restart) else $error("step not cleared while disabled");

   property p_saturate;
      @(posedge sys_clk) disable iff (!arst_n)
         ssi.done && ssi.run |=> ssi.step == lsdc_pkg::STEP_FULL;
   endproperty
   a_saturate: assert property (p_saturate) else $error("step left full scale");

   c_done: cover property (@(posedge sys_clk) disable iff (!arst_n) $rose(ssi.done));
   c_held: cover property (@(posedge sys_clk) disable iff (!arst_n)
      interval_up && !seen && !ssi.conduct && state == lsdc_pkg::LSDC_RAMP);
endmodule : lsdc_softstart

// File: rtl/lsdc_top.sv
// soft-start sequencer and enable-qualified pwm dimming for eight channels
`timescale 1ns/10ps
// Notes on behaviour
// - current limit ramps in exactly eight increments
// - ramp starts at one ninth full scale
// - each increment adds one ninth, 2 ms apart
// - hold step until some channel conducts
// - re-enable restarts soft-start from first step
// - no current control while enable low
// - channel on/off follows external pwm input, ANDed with bus_pwm while bus_dim_en is high
// - all eight channels gated together
// - duty 0.4 to 100 percent up to 30 kHz
// - undervoltage lockout resets all digital state
module lsdc_top #(
   parameter int STEP_CYCLES = lsdc_pkg::STEP_CYCLES
) (
   input  wire logic        sys_clk,
   input  wire logic        arst_n,
   input  wire logic        uvlo,
   input  wire logic        led_en,
   input  wire logic        pwm_in,
   input  wire logic        bus_dim_en,
   input  wire logic        bus_pwm,
   input  wire logic [7:0]  ch_conduct,
   output logic      [3:0]  ilim_step,
   output logic             ss_done,
   output logic             boost_run,
   output logic      [7:0]  ch_on
);
   lsdc_ss_if ssi ();
   logic      lock_n;
   logic      pwm_sel;

   // -------------------------------------------------------------
   // lockout and enable qualification
   // -------------------------------------------------------------
   // uvlo clears everything synchronously; arst_n stays the only async reset
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         lock_n <= 1'b0;
      end else begin
         lock_n <= !uvlo;
      end
   end

   assign ssi.run     = led_en && lock_n && !uvlo;
   assign ssi.conduct = |ch_conduct;

   lsdc_softstart #(
      .STEP_CYCLES (STEP_CYCLES)
   ) u_ss (
      .sys_clk (sys_clk),
      .arst_n  (arst_n),
      .ssi     (ssi)
   );

   // -------------------------------------------------------------
   // dimming path
   // -------------------------------------------------------------
   // standalone mode uses pwm_in; bus idle means bus_dim_en low
   assign pwm_sel = bus_dim_en ? (bus_pwm && pwm_in) : pwm_in;

   // no pulse filtering, so short duties pass one clock at 10 ns
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         ch_on     <= lsdc_pkg::CH_ALL_OFF;
         boost_run <= 1'b0;
      end else begin
         ch_on     <= (ssi.run && pwm_sel) ? lsdc_pkg::CH_ALL_ON
                                           : lsdc_pkg::CH_ALL_OFF;
         boost_run <= ssi.run;
      end
   end

   assign ilim_step = ssi.step;
   assign ss_done   = ssi.done;

   // -------------------------------------------------------------
   // checks
   // -------------------------------------------------------------
   property p_off_when_disabled;
      @(posedge sys_clk) disable iff (!arst_n)
         !led_en |=> ch_on == lsdc_pkg::CH_ALL_OFF && !boost_run;
   endproperty
   a_off_when_disabled: assert property (p_off_when_disabled) else $error("current while disabled");

   property p_track_pwm;
      @(posedge sys_clk) disable iff (!arst_n)
         ssi.run && !bus_dim_en |=> ch_on == {lsdc_pkg::NUM_CH{$past(pwm_in)}};
   endproperty
   a_track_pwm: assert property (p_track_pwm) else $error("channels do not follow pwm input");

   property p_gang;
      @(posedge sys_clk) disable iff (!arst_n)
         ch_on == lsdc_pkg::CH_ALL_ON || ch_on == lsdc_pkg::CH_ALL_OFF;
   endproperty
   a_gang: assert property (p_gang) else $error("channels not gated together");

   property p_uvlo;
      @(posedge sys_clk) disable iff (!arst_n)
         uvlo |=> !boost_run && ilim_step == lsdc_pkg::STEP_OFF ##1 !ss_done;
   endproperty
   a_uvlo: assert property (p_uvlo) else $error("state kept through lockout");

   c_pwm_on:  cover property (@(posedge sys_clk) disable iff (!arst_n) $rose(ch_on[0]));
   c_reen:    cover property (@(posedge sys_clk) disable iff (!arst_n) $rose(led_en));
   c_uvlo:    cover property (@(posedge sys_clk) disable iff (!arst_n) $rose(uvlo) && ss_done);
endmodule : lsdc_top

// File: testbench/lsdc_host.sv
// host pwm source and string conduction model for the dimming slice
`timescale 1ns/10ps
module lsdc_host (
   input  wire logic       sys_clk,
   input  wire logic       en_req,
   input  wire logic       pwm_req,
   input  wire logic       bus_req,
   input  wire logic       bus_lvl,
   input  wire logic [7:0] ch_on,
   output logic            led_en,
   output logic            pwm_in,
   output logic            bus_dim_en,
   output logic            bus_pwm,
   output logic      [7:0] ch_conduct
);
   initial begin
      {led_en, pwm_in, bus_dim_en, bus_pwm} = 4'h0;
      ch_conduct = 8'h00;
   end
   // strings only conduct while gated on, one cycle late
   always @(posedge sys_clk) begin
      led_en     <= en_req;
      pwm_in     <= pwm_req;
      bus_dim_en <= bus_req;
      bus_pwm    <= bus_req & bus_lvl;
      ch_conduct <= ch_on;
   end
endmodule : lsdc_host

// File: testbench/tb.sv
// self-checking bench for the soft-start and dimming slice
`timescale 1ns/10ps
module tb;
   localparam int SC = 8;
   logic        sys_clk = 1'b0;
   logic        arst_n = 1'b0;
   logic        uvlo = 1'b0;
   logic        en_req = 1'b0;
   logic        pwm_req = 1'b1;
   logic        bus_req = 1'b0;
   logic        bus_lvl = 1'b0;
   logic        led_en, pwm_in, bus_dim_en, bus_pwm, ss_done, boost_run;
   logic [7:0]  ch_conduct, ch_on;
   logic [3:0]  ilim_step;
   logic [3:0]  last = 4'h0;
   logic        psel = 1'b0;
   logic        plock = 1'b0;
   logic        prun = 1'b0;
   logic [3:0]  cur = 4'h0;
   logic [31:0] seed = 32'h5bf8;
   logic [3:0]  exp_q[$];
   int          lo_q[$], hi_q[$];
   int          gap = 0, failures = 0, tests_run = 0;
   always #5 sys_clk = ~sys_clk;
   lsdc_top #(.STEP_CYCLES(SC)) uut (.sys_clk, .arst_n, .uvlo, .led_en, .pwm_in,
      .bus_dim_en, .bus_pwm, .ch_conduct, .ilim_step, .ss_done, .boost_run, .ch_on);
   lsdc_host host (.sys_clk, .en_req, .pwm_req, .bus_req, .bus_lvl, .ch_on,
      .led_en, .pwm_in, .bus_dim_en, .bus_pwm, .ch_conduct);
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction : xs
   task automatic chk_step(input string w, input logic [3:0] e, input logic [3:0] g);
      tests_run++;
      if (g !== e) begin
         failures++;
         $display("ERROR %s expected %h seen %h", w, e, g);
      end
   endtask : chk_step
   task automatic chk_gate(input string w, input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         failures++;
         $display("ERROR %s expected %h seen %h", w, e, g);
      end
   endtask : chk_gate
   task automatic push(input logic [3:0] s, input int lo, input int hi);
      exp_q.push_back(s);
      lo_q.push_back(lo);
      hi_q.push_back(hi);
   endtask : push
   task automatic ramp(input int from);
      for (int i = from; i <= 9; i++) push(4'(i), SC, SC + 1);
   endtask : ramp
   // extra idle cycles catch a step past full scale
   task automatic drain(input string name);
      for (int i = 0; i < 600 && exp_q.size() > 0; i++) @(posedge sys_clk);
      repeat (3 * SC) @(posedge sys_clk);
      chk_gate("pending steps", 8'h00, 8'(exp_q.size()));
      $display("test %s done", name);
   endtask : drain
   task automatic end_sim;
      $display("tests %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : end_sim
   // ---------------------------------------------------------------
   // output watcher, sampled mid-cycle where outputs are settled
   // ---------------------------------------------------------------
   always @(negedge sys_clk) begin
      if (arst_n) begin
         gap++;
         if (ilim_step !== last) begin
            if (exp_q.size() == 0) chk_step("unexpected step", last, ilim_step);
            else begin
               cur = exp_q.pop_front();
               chk_step("ilim_step", cur, ilim_step);
               chk_gate("spacing", 8'h01, {7'h00, gap >= lo_q[0] && gap <= hi_q[0]});
               void'(lo_q.pop_front());
               void'(hi_q.pop_front());
            end
            gap = 0;
         end
         chk_gate("ss_done", {7'h00, cur == lsdc_pkg::STEP_FULL}, {7'h00, ss_done});
         chk_gate("ch_on", prun ? {8{psel}} : lsdc_pkg::CH_ALL_OFF, ch_on);
         chk_gate("boost_run", {7'h00, prun}, {7'h00, boost_run});
      end
      last = ilim_step;
      psel = bus_dim_en ? bus_pwm & pwm_in : pwm_in;
      // run as sampled at the next edge; lockout lingers one edge after uvlo falls
      prun = led_en & !uvlo & plock;
      plock = arst_n & !uvlo;
   end
   // ---------------------------------------------------------------
   // tests
   // ---------------------------------------------------------------
   initial begin
      repeat (8) @(posedge sys_clk);
      arst_n <= 1'b1;
      push(4'h1, 0, 1000);
      ramp(2);
      en_req <= 1'b1;
      drain("ramp");
      push(4'h0, 0, 1000);
      en_req <= 1'b0;
      drain("disable");
      push(4'h1, 0, 1000);
      push(4'h2, SC, SC + 1);
      push(4'h3, 30, 1000);
      ramp(4);
      en_req <= 1'b1;
      for (int i = 0; i < 100 && ilim_step !== 4'h1; i++) @(posedge sys_clk);
      // dark strings stall the ramp at the next step
      pwm_req <= 1'b0;
      repeat (45) @(posedge sys_clk);
      pwm_req <= 1'b1;
      drain("hold and restart");
      repeat (300) begin
         @(posedge sys_clk);
         seed = xs(seed);
         pwm_req <= seed[0];
         bus_req <= seed[9];
         bus_lvl <= seed[4];
      end
      pwm_req <= 1'b1;
      bus_req <= 1'b0;
      push(4'h0, 0, 1000);
      uvlo <= 1'b1;
      repeat (3) @(posedge sys_clk);
      uvlo <= 1'b0;
      push(4'h1, 0, 1000);
      ramp(2);
      drain("lockout");
      end_sim;
   end
   initial begin
      repeat (4000) @(posedge sys_clk);
      failures++;
      end_sim;
   end
endmodule : tb
